// File: chip_control_regs.sv
// chip-level control and configuration register bank
`timescale 1ns/1ps
// Behaviour
// - trace enable set disables gpio 1-9, clear enables them.
// - bits 5-11 pick chip select or gpio 10-16 per line.
// - bits 12-18 route irq 0-6 to controller or gpio; gpio forces irq zero.
// - bit 19 picks dsr or cts, bit 20 picks rts or dtr.
// - bits 21, 22 enable serial port 0 dma transmit and receive.
// - with bit 23 set, terminal count clears the matching dma enable.
// - bits 24, 25 choose external or divided serial clock per port.
// - serial divisor divides processor clock by field plus one.
// - chip control 1 bit 8 picks processor or external timer clock.
// - chip control 1 bit 17 picks pci irq or peripheral write enable.
// - power enable and force hold bits 0-16, rest reserved.
// - identity register gives maker, part, site and version fields.
// - forward divisor is eight minus code.
// - feedback divisor is its code, zero meaning sixteen.
// - core, peripheral, pci bus divisors are code plus one.
// - external bus ratio is code plus two.
// - strap forward divider: bypass, 3, 4 or 6.
// - strap feedback divider is code plus one.
// - strap tuning choice maps to 010001..010111, code 111 to 100100.
// - strap external divider is code plus two; boot width 8 or 32.
module chip_control_regs
  import chip_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // device control bus
  input wire logic i_dcr_read,
  input wire logic i_dcr_write,
  input wire logic [9:0] i_dcr_abus,
  input wire logic [31:0] i_dcr_dbus,
  output logic [31:0] o_dcr_dbus,
  output logic o_dcr_ack,
  // straps and status from the chip
  input wire logic [15:0] i_straps,
  input wire logic i_tx_terminal_count,
  input wire logic i_rx_terminal_count,
  input wire logic [6:0] i_ext_irq,
  input wire logic [NUM_UNITS-1:0] i_unit_idle,
  // pin function selects
  output logic o_gpio_1_9_enable,
  output logic [6:0] o_cs_as_gpio,
  output logic [6:0] o_irq_as_gpio,
  output logic [6:0] o_irq_to_controller,
  output logic o_modem_input_select,
  output logic o_modem_output_select,
  output logic o_serial_dma_tx_enable,
  output logic o_serial_dma_rx_enable,
  output logic o_port0_ext_clock_sel,
  output logic o_port1_ext_clock_sel,
  output logic [5:0] o_serial_clock_div,
  output logic o_timer_ext_clock_sel,
  output logic o_pci_irq_or_write_enable,
  // clock generator decode
  output logic [3:0] o_forward_div,
  output logic [4:0] o_feedback_div,
  output logic [5:0] o_jitter_tuning,
  output logic [2:0] o_core_to_local_bus_div,
  output logic [2:0] o_periph_to_local_bus_div,
  output logic [2:0] o_pci_to_local_bus_div,
  output logic [2:0] o_ext_bus_ratio,
  output logic [3:0] o_strap_forward_div,
  output logic [2:0] o_strap_feedback_div,
  output logic [5:0] o_strap_tuning,
  output logic [2:0] o_strap_ext_bus_div,
  output logic [5:0] o_boot_width,
  // unit clock stops
  output logic [NUM_UNITS-1:0] o_unit_clock_stop
);
  ////////////////////////////////////////////////////////////////////
  // state
  bus_state_t state, next_state;
  logic [31:0] clock_divider_mode, next_clock_divider_mode;
  logic [31:0] chip_control_zero, next_chip_control_zero;
  logic [31:0] chip_control_one, next_chip_control_one;
  logic [31:0] power_mgmt_enable, next_power_mgmt_enable;
  logic [31:0] power_mgmt_force, next_power_mgmt_force;
  logic [15:0] strap_readback, next_strap_readback;
  logic strap_taken, next_strap_taken;
  logic [31:0] rd_data, next_rd_data;
  logic ack, next_ack;
  logic [31:0] wdata_merged;
  divisor_if dv();

  // masked merge of write data into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] mask);
    return (old & ~mask) | (wd & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // divisor decode
  assign dv.mode = clock_divider_mode;
  assign dv.straps = strap_readback;
  assign dv.serial_div = 6'd0;
  divisor_decode u_dec (
    .d(dv)
  );

  ////////////////////////////////////////////////////////////////////
  // bus access and register updates
  always_comb begin
    next_state = state;
    next_clock_divider_mode = clock_divider_mode;
    next_chip_control_zero = chip_control_zero;
    next_chip_control_one = chip_control_one;
    next_power_mgmt_enable = power_mgmt_enable;
    next_power_mgmt_force = power_mgmt_force;
    next_strap_readback = strap_readback;
    next_strap_taken = 1'b1;
    next_rd_data = rd_data;
    next_ack = 1'b0;
    wdata_merged = 32'h0000_0000;
    // straps caught once after reset release
    if (!strap_taken) begin
      next_strap_readback = i_straps;
    end
    // terminal count clears dma enables
    if (chip_control_zero[CR0_AUTOCLEAR]) begin
      if (i_tx_terminal_count) begin
        next_chip_control_zero[CR0_DMA_TX] = 1'b0;
      end
      if (i_rx_terminal_count) begin
        next_chip_control_zero[CR0_DMA_RX] = 1'b0;
      end
    end
    case (state)
      ST_IDLE: begin
        if (i_dcr_write) begin
          next_state = ST_ACK;
          next_ack = 1'b1;
          case (i_dcr_abus)
            ADDR_CLOCK_DIVIDER_MODE: begin
              next_clock_divider_mode = merge(32'h0, i_dcr_dbus, MASK_CLOCK_DIVIDER_MODE);
            end
            ADDR_CHIP_CONTROL_ZERO: begin
              wdata_merged = merge(32'h0, i_dcr_dbus, MASK_CHIP_CONTROL_ZERO);
              // a terminal count in the same cycle still clears the bit
              if (chip_control_zero[CR0_AUTOCLEAR] && i_tx_terminal_count) begin
                wdata_merged[CR0_DMA_TX] = 1'b0;
              end
              if (chip_control_zero[CR0_AUTOCLEAR] && i_rx_terminal_count) begin
                wdata_merged[CR0_DMA_RX] = 1'b0;
              end
              next_chip_control_zero = wdata_merged;
            end
            ADDR_CHIP_CONTROL_ONE: begin
              next_chip_control_one = merge(32'h0, i_dcr_dbus, MASK_CHIP_CONTROL_ONE);
            end
            ADDR_POWER_MGMT_ENABLE: begin
              next_power_mgmt_enable = merge(32'h0, i_dcr_dbus, MASK_POWER_MGMT);
            end
            ADDR_POWER_MGMT_FORCE: begin
              next_power_mgmt_force = merge(32'h0, i_dcr_dbus, MASK_POWER_MGMT);
            end
            default: begin
            end
          endcase
        end else if (i_dcr_read) begin
          next_state = ST_ACK;
          next_ack = 1'b1;
          case (i_dcr_abus)
            ADDR_CLOCK_DIVIDER_MODE: next_rd_data = clock_divider_mode;
            ADDR_CHIP_CONTROL_ZERO: next_rd_data = chip_control_zero;
            ADDR_CHIP_CONTROL_ONE: next_rd_data = chip_control_one;
            ADDR_STRAP_READBACK: next_rd_data = {strap_readback, 16'h0000};
            ADDR_TEST_PORT_IDENTITY: begin
              next_rd_data = {ID_MAKER, ID_PART, ID_SITE, ID_VERSION};
            end
            ADDR_POWER_MGMT_ENABLE: next_rd_data = power_mgmt_enable;
            ADDR_POWER_MGMT_FORCE: next_rd_data = power_mgmt_force;
            default: next_rd_data = 32'h0000_0000;
          endcase
        end
      end
      ST_ACK: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        // hold off until the strobe drops
        if (!i_dcr_read && !i_dcr_write) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // register the bank
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_IDLE;
      clock_divider_mode <= RST_CLOCK_DIVIDER_MODE;
      chip_control_zero <= RST_CHIP_CONTROL_ZERO;
      chip_control_one <= RST_CHIP_CONTROL_ONE;
      power_mgmt_enable <= RST_POWER_MGMT;
      power_mgmt_force <= RST_POWER_MGMT;
      strap_readback <= 16'h0000;
      strap_taken <= 1'b0;
      rd_data <= 32'h0000_0000;
      ack <= 1'b0;
    end else begin
      state <= next_state;
      clock_divider_mode <= next_clock_divider_mode;
      chip_control_zero <= next_chip_control_zero;
      chip_control_one <= next_chip_control_one;
      power_mgmt_enable <= next_power_mgmt_enable;
      power_mgmt_force <= next_power_mgmt_force;
      strap_readback <= next_strap_readback;
      strap_taken <= next_strap_taken;
      rd_data <= next_rd_data;
      ack <= next_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registered pin-function outputs
  logic [NUM_UNITS-1:0] next_stop;
  logic [6:0] next_irq;
  always_comb begin
    for (int i = 0; i < NUM_UNITS; i++) begin
      // documented unit n sits at lsb-numbered bit 31-n
      next_stop[i] = power_mgmt_force[31-i] | (power_mgmt_enable[31-i] & i_unit_idle[i]);
    end
    for (int j = 0; j < 7; j++) begin
      // irq j is forced low when its pin serves as gpio
      next_irq[j] = i_ext_irq[j] & ~chip_control_zero[CR0_IRQ_LSB + 6 - j];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dcr_dbus <= 32'h0000_0000;
      o_dcr_ack <= 1'b0;
      o_gpio_1_9_enable <= 1'b1;
      o_cs_as_gpio <= 7'h00;
      o_irq_as_gpio <= 7'h00;
      o_irq_to_controller <= 7'h00;
      o_modem_input_select <= 1'b0;
      o_modem_output_select <= 1'b0;
      o_serial_dma_tx_enable <= 1'b0;
      o_serial_dma_rx_enable <= 1'b0;
      o_port0_ext_clock_sel <= 1'b0;
      o_port1_ext_clock_sel <= 1'b0;
      o_serial_clock_div <= 6'd1;
      o_timer_ext_clock_sel <= 1'b0;
      o_pci_irq_or_write_enable <= 1'b0;
      o_forward_div <= 4'd8;
      o_feedback_div <= 5'd16;
      o_jitter_tuning <= 6'h00;
      o_core_to_local_bus_div <= 3'd1;
      o_periph_to_local_bus_div <= 3'd1;
      o_pci_to_local_bus_div <= 3'd1;
      o_ext_bus_ratio <= 3'd2;
      o_strap_forward_div <= 4'd1;
      o_strap_feedback_div <= 3'd1;
      o_strap_tuning <= 6'b010001;
      o_strap_ext_bus_div <= 3'd2;
      o_boot_width <= 6'd8;
      o_unit_clock_stop <= '0;
    end else begin
      o_dcr_dbus <= next_rd_data;
      o_dcr_ack <= next_ack;
      o_gpio_1_9_enable <= ~chip_control_zero[CR0_TRACE];
      o_cs_as_gpio <= {<<{chip_control_zero[CR0_CS_LSB +: 7]}};
      o_irq_as_gpio <= {<<{chip_control_zero[CR0_IRQ_LSB +: 7]}};
      o_irq_to_controller <= next_irq;
      o_modem_input_select <= chip_control_zero[CR0_MODEM_IN];
      o_modem_output_select <= chip_control_zero[CR0_MODEM_OUT];
      o_serial_dma_tx_enable <= chip_control_zero[CR0_DMA_TX];
      o_serial_dma_rx_enable <= chip_control_zero[CR0_DMA_RX];
      o_port0_ext_clock_sel <= chip_control_zero[CR0_P0_EXT];
      o_port1_ext_clock_sel <= chip_control_zero[CR0_P1_EXT];
      // field msb already sits at the higher bit, no reversal
      o_serial_clock_div <= {1'b0, chip_control_zero[CR0_DIV_LSB +: 5]} + 6'd1;
      o_timer_ext_clock_sel <= chip_control_one[CR1_TIMER];
      o_pci_irq_or_write_enable <= chip_control_one[CR1_PCI_WE];
      o_forward_div <= dv.fwd_div;
      o_feedback_div <= dv.fbk_div;
      o_jitter_tuning <= clock_divider_mode[PM_TUN_LSB +: 6];
      o_core_to_local_bus_div <= dv.core_div;
      o_periph_to_local_bus_div <= dv.peri_div;
      o_pci_to_local_bus_div <= dv.pci_div;
      o_ext_bus_ratio <= dv.ext_ratio;
      o_strap_forward_div <= dv.strap_fwd;
      o_strap_feedback_div <= dv.strap_fbk;
      o_strap_tuning <= dv.strap_tune;
      o_strap_ext_bus_div <= dv.strap_ext;
      // only the width code msb is strapped: 00 gives 8, 10 gives 32
      o_boot_width <= strap_readback[0] ? 6'd32 : 6'd8;
      o_unit_clock_stop <= next_stop;
    end
  end
endmodule

// File: chip_control_regs_properties.sv
// property checker for the chip control register bank
`timescale 1ns/1ps
module chip_control_regs_properties
  import chip_ctrl_pkg::*;
(
  // clock, reset and bus handshake
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_dcr_read,
  input wire logic i_dcr_write,
  input wire logic o_dcr_ack,
  // decoded outputs
  input wire logic [6:0] o_irq_as_gpio,
  input wire logic [6:0] o_irq_to_controller,
  input wire logic [5:0] o_serial_clock_div,
  input wire logic [3:0] o_forward_div,
  input wire logic [4:0] o_feedback_div,
  input wire logic [2:0] o_core_to_local_bus_div,
  input wire logic [2:0] o_ext_bus_ratio,
  input wire logic [5:0] o_strap_tuning
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////
  // bus handshake
  a_ack_one_cycle: assert property (o_dcr_ack |=> !o_dcr_ack)
    else $error("ack longer than one cycle");
  a_ack_follows_req: assert property ($rose(i_dcr_read || i_dcr_write) |=> o_dcr_ack)
    else $error("request not answered next cycle");
  // interrupts stay off the controller for pins that are gpio this cycle and the last; decoded fields stay inside their documented ranges
  a_irq_isolated: assert property ((o_irq_to_controller & o_irq_as_gpio & $past(o_irq_as_gpio)) == 7'h00)
    else $error("interrupt reaches controller while pin is gpio");
  a_serial_div_range: assert property (o_serial_clock_div inside {[6'd1:6'd32]})
    else $error("serial divisor out of range");
  a_fwd_range: assert property (o_forward_div inside {[4'd1:4'd8]})
    else $error("forward divisor out of range");
  a_fbk_range: assert property (o_feedback_div inside {[5'd1:5'd16]})
    else $error("feedback divisor out of range");
  a_core_div_range: assert property (o_core_to_local_bus_div inside {[3'd1:3'd4]})
    else $error("core bus divisor out of range");
  a_ext_ratio_range: assert property (o_ext_bus_ratio inside {[3'd2:3'd5]})
    else $error("external bus ratio out of range");
  a_tune_choice: assert property (o_strap_tuning inside {[6'h11:6'h17], 6'h24})
    else $error("strap tuning value not a listed choice");
  // main scenarios
  c_write_ack: cover property (o_dcr_ack && $past(i_dcr_write));
  c_read_ack: cover property (o_dcr_ack && $past(i_dcr_read));
  c_irq_gpio: cover property ($rose(o_irq_as_gpio[0]));
endmodule
bind chip_control_regs chip_control_regs_properties u_props (.i_ref_clk, .i_arst_n,
  .i_dcr_read, .i_dcr_write, .o_dcr_ack, .o_irq_as_gpio, .o_irq_to_controller,
  .o_serial_clock_div, .o_forward_div, .o_feedback_div, .o_core_to_local_bus_div,
  .o_ext_bus_ratio, .o_strap_tuning);

// File: chip_control_regs_tb.sv
// self-checking bench for the chip control register bank
`timescale 1ns/1ps
module chip_control_regs_tb;
  import chip_ctrl_pkg::*;
  logic i_ref_clk, i_arst_n, i_dcr_read, i_dcr_write, i_tx_terminal_count, i_rx_terminal_count;
  logic o_dcr_ack, o_gpio_1_9_enable, o_modem_input_select, o_modem_output_select;
  logic o_serial_dma_tx_enable, o_serial_dma_rx_enable, o_port0_ext_clock_sel;
  logic o_port1_ext_clock_sel, o_timer_ext_clock_sel, o_pci_irq_or_write_enable;
  logic [6:0] i_ext_irq, o_cs_as_gpio, o_irq_as_gpio, o_irq_to_controller;
  logic [5:0] o_serial_clock_div, o_jitter_tuning, o_strap_tuning, o_boot_width;
  logic [3:0] o_forward_div, o_strap_forward_div;
  logic [4:0] o_feedback_div;
  logic [2:0] o_core_to_local_bus_div, o_periph_to_local_bus_div, o_pci_to_local_bus_div;
  logic [2:0] o_ext_bus_ratio, o_strap_feedback_div, o_strap_ext_bus_div;
  logic [9:0] i_dcr_abus;
  logic [31:0] i_dcr_dbus, o_dcr_dbus, d, rd;
  logic [15:0] i_straps, s;
  logic [NUM_UNITS-1:0] i_unit_idle, o_unit_clock_stop;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 79077;
  // writable registers, their writable bits and shadow copies
  logic [9:0] adr [5] = '{ADDR_CLOCK_DIVIDER_MODE, ADDR_CHIP_CONTROL_ZERO,
    ADDR_CHIP_CONTROL_ONE, ADDR_POWER_MGMT_ENABLE, ADDR_POWER_MGMT_FORCE};
  logic [31:0] msk [5] = '{32'hffff_f800, 32'h0fff_fffe, 32'h0080_4000, 32'hffff_8000,
    32'hffff_8000};
  logic [31:0] sh [5];

  chip_control_regs DUT (.i_ref_clk, .i_arst_n, .i_dcr_read, .i_dcr_write, .i_dcr_abus,
    .i_dcr_dbus, .o_dcr_dbus, .o_dcr_ack, .i_straps, .i_tx_terminal_count,
    .i_rx_terminal_count, .i_ext_irq, .i_unit_idle, .o_gpio_1_9_enable, .o_cs_as_gpio,
    .o_irq_as_gpio, .o_irq_to_controller, .o_modem_input_select, .o_modem_output_select,
    .o_serial_dma_tx_enable, .o_serial_dma_rx_enable, .o_port0_ext_clock_sel,
    .o_port1_ext_clock_sel, .o_serial_clock_div, .o_timer_ext_clock_sel,
    .o_pci_irq_or_write_enable, .o_forward_div, .o_feedback_div, .o_jitter_tuning,
    .o_core_to_local_bus_div, .o_periph_to_local_bus_div, .o_pci_to_local_bus_div,
    .o_ext_bus_ratio, .o_strap_forward_div, .o_strap_feedback_div, .o_strap_tuning,
    .o_strap_ext_bus_div, .o_boot_width, .o_unit_clock_stop);
  ////////////////////////////////////////
  // clock at 50 ns period
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  // expected strap decodes
  function automatic logic [5:0] tune_of(input logic [2:0] c);
    return (c == 3'h7) ? 6'h24 : 6'h11 + c;
  endfunction
  function automatic logic [3:0] fwd_of(input logic [1:0] c);
    return (c == 2'h1) ? 4'h3 : (c == 2'h2) ? 4'h4 : 4'h6;
  endfunction
  // index i of a pin vector is documented line i, highest register bit first
  function automatic logic [16:0] rev17(input logic [16:0] v);
    logic [16:0] r;
    for (int i = 0; i < 17; i++) r[i] = v[16-i];
    return r;
  endfunction
  function automatic logic [6:0] rev7(input logic [6:0] v);
    logic [6:0] r;
    for (int i = 0; i < 7; i++) r[i] = v[6-i];
    return r;
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus access, strobe held until ack, data taken with ack
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_dcr_write <= wr;
    i_dcr_read <= !wr;
    i_dcr_abus <= a;
    i_dcr_dbus <= dat;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_dcr_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("unexpected at %0t: no ack", $time);
    end
    rd = o_dcr_dbus;
    @(posedge i_ref_clk);
    i_dcr_write <= 1'b0;
    i_dcr_read <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
  endtask
  task automatic do_reset(input logic [15:0] st);
    i_arst_n <= 1'b0;
    i_straps <= st;
    repeat (12) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
  endtask
  task automatic tc_pulse(input logic tx, input logic rx);
    i_tx_terminal_count <= tx;
    i_rx_terminal_count <= rx;
    @(posedge i_ref_clk);
    i_tx_terminal_count <= 1'b0;
    i_rx_terminal_count <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
  endtask
  // decoded outputs against shadow registers
  task automatic check_outs();
    repeat (2) @(posedge i_ref_clk);
    chk(o_gpio_1_9_enable, !sh[1][27]);
    chk(o_cs_as_gpio, rev7(sh[1][26:20]));
    chk(o_irq_as_gpio, rev7(sh[1][19:13]));
    chk(o_irq_to_controller, i_ext_irq & ~rev7(sh[1][19:13]));
    chk({o_modem_input_select, o_modem_output_select}, sh[1][12:11]);
    chk({o_serial_dma_tx_enable, o_serial_dma_rx_enable}, sh[1][10:9]);
    chk({o_port0_ext_clock_sel, o_port1_ext_clock_sel}, sh[1][7:6]);
    chk(o_serial_clock_div, sh[1][5:1] + 1);
    chk(o_timer_ext_clock_sel, sh[2][23]);
    chk(o_pci_irq_or_write_enable, sh[2][14]);
    chk(o_forward_div, 8 - sh[0][31:29]);
    chk(o_feedback_div, (sh[0][28:25] == 4'h0) ? 16 : sh[0][28:25]);
    chk(o_jitter_tuning, sh[0][24:19]);
    chk({o_core_to_local_bus_div, o_periph_to_local_bus_div, o_pci_to_local_bus_div},
      {sh[0][18:17] + 3'd1, sh[0][16:15] + 3'd1, sh[0][14:13] + 3'd1});
    chk(o_ext_bus_ratio, sh[0][12:11] + 2);
    chk(o_unit_clock_stop, rev17(sh[4][31:15]) | (rev17(sh[3][31:15]) & i_unit_idle));
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(20000 * 50);
    error_cnt++;
    $display("unexpected at %0t: watchdog", $time);
    end_sim();
  end
  // main sequence
  initial begin
    {i_dcr_read, i_dcr_write, i_tx_terminal_count, i_rx_terminal_count} = 4'h0;
    {i_dcr_abus, i_dcr_dbus, i_ext_irq, i_unit_idle} = '0;
    i_arst_n = 1'b0;
    i_straps = 16'h0000;
    do_reset(16'h0000);
    for (int k = 0; k < 5; k++) begin
      sh[k] = 32'h0;
      bus(0, adr[k], 0);
      chk(rd, 32'h0);
    end
    check_outs();
    // every forward, feedback and serial divisor code, random fields elsewhere
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 5; k++) begin
        d = $random(seed);
        if (k == 0) d[31:25] = {i[2:0], i[3:0]};
        if (k == 1) d[5:1] = i[4:0];
        bus(1, adr[k], d);
        sh[k] = d & msk[k];
        bus(0, adr[k], 0);
        chk(rd, sh[k]);
      end
      i_ext_irq <= 7'($random(seed));
      i_unit_idle <= NUM_UNITS'($random(seed));
      check_outs();
    end
    // read-only and unmapped places
    bus(1, ADDR_TEST_PORT_IDENTITY, 32'hffff_ffff);
    bus(1, 10'h0b4, 32'hffff_ffff);
    bus(0, ADDR_TEST_PORT_IDENTITY, 0);
    chk(rd, {ID_MAKER, ID_PART, ID_SITE, ID_VERSION});
    bus(0, 10'h0b4, 0);
    chk(rd, 32'h0);
    for (int k = 0; k < 5; k++) begin
      bus(0, adr[k], 0);
      chk(rd, sh[k]);
    end
    // terminal counts with and without autoclear
    bus(1, ADDR_CHIP_CONTROL_ZERO, 32'h0000_0700);
    tc_pulse(1, 0);
    chk({o_serial_dma_tx_enable, o_serial_dma_rx_enable}, 2'b01);
    tc_pulse(0, 1);
    bus(0, ADDR_CHIP_CONTROL_ZERO, 0);
    chk(rd, 32'h0000_0100);
    bus(1, ADDR_CHIP_CONTROL_ZERO, 32'h0000_0600);
    tc_pulse(1, 1);
    chk({o_serial_dma_tx_enable, o_serial_dma_rx_enable}, 2'b11);
    // resets in mid-run with every strap tuning code
    for (int i = 0; i < 8; i++) begin
      s = 16'($random(seed));
      s[11:9] = i[2:0];
      do_reset(s);
      bus(0, ADDR_STRAP_READBACK, 0);
      chk(rd[31:16], s);
      if (s[15:14] != 2'h0) chk(o_strap_forward_div, fwd_of(s[15:14]));
      chk(o_strap_feedback_div, s[13:12] + 1);
      chk(o_strap_tuning, tune_of(s[11:9]));
      chk(o_strap_ext_bus_div, s[2:1] + 2);
      chk(o_boot_width, s[0] ? 32 : 8);
      bus(0, ADDR_CHIP_CONTROL_ZERO, 0);
      chk(rd, 32'h0);
    end
    end_sim();
  end
endmodule

// File: chip_ctrl_pkg.sv
// chip control register bank constants
package chip_ctrl_pkg;
  // register numbers on the device control bus
  localparam logic [9:0] ADDR_CLOCK_DIVIDER_MODE = 10'h00b;
  localparam logic [9:0] ADDR_CHIP_CONTROL_ZERO = 10'h0b1;
  localparam logic [9:0] ADDR_CHIP_CONTROL_ONE = 10'h0b2;
  localparam logic [9:0] ADDR_STRAP_READBACK = 10'h0b3;
  localparam logic [9:0] ADDR_TEST_PORT_IDENTITY = 10'h0b5;
  localparam logic [9:0] ADDR_POWER_MGMT_ENABLE = 10'h0b9;
  localparam logic [9:0] ADDR_POWER_MGMT_FORCE = 10'h0ba;
  // reset values
  localparam logic [31:0] RST_CLOCK_DIVIDER_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_CHIP_CONTROL_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_CHIP_CONTROL_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_POWER_MGMT = 32'h0000_0000;
  // writable masks, lsb-numbered (documented bit n sits at 31-n)
  localparam logic [31:0] MASK_CHIP_CONTROL_ZERO = 32'h0fff_fffe;
  localparam logic [31:0] MASK_CHIP_CONTROL_ONE = 32'h0080_4000;
  localparam logic [31:0] MASK_CLOCK_DIVIDER_MODE = 32'hffff_f800;
  localparam logic [31:0] MASK_POWER_MGMT = 32'hffff_8000;
  // chip control zero fields
  localparam int CR0_TRACE = 27;
  localparam int CR0_CS_LSB = 20;
  localparam int CR0_IRQ_LSB = 13;
  localparam int CR0_MODEM_IN = 12;
  localparam int CR0_MODEM_OUT = 11;
  localparam int CR0_DMA_TX = 10;
  localparam int CR0_DMA_RX = 9;
  localparam int CR0_AUTOCLEAR = 8;
  localparam int CR0_P0_EXT = 7;
  localparam int CR0_P1_EXT = 6;
  localparam int CR0_DIV_LSB = 1;
  // chip control one fields
  localparam int CR1_TIMER = 23;
  localparam int CR1_PCI_WE = 14;
  // clock divider mode fields
  localparam int PM_FWD_LSB = 29;
  localparam int PM_FBK_LSB = 25;
  localparam int PM_TUN_LSB = 19;
  localparam int PM_CORE_LSB = 17;
  localparam int PM_PERI_LSB = 15;
  localparam int PM_PCI_LSB = 13;
  localparam int PM_EXT_LSB = 11;
  // identity fields, arbitrary values
  localparam logic [11:0] ID_MAKER = 12'h5a5;
  localparam logic [11:0] ID_PART = 12'h123;
  localparam logic [3:0] ID_SITE = 4'h1;
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam int NUM_UNITS = 17;
  // bus access states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK = 3'b010,
    ST_WAIT = 3'b100
  } bus_state_t;
endpackage

// File: divisor_decode.sv
// decodes divisor codes from mode register and straps
`timescale 1ns/1ps
module divisor_decode
  import chip_ctrl_pkg::*;
(
  divisor_if.dec d
);
  // two-bit code plus one
  function automatic logic [2:0] plus_one(input logic [1:0] c);
    return {1'b0, c} + 3'd1;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // combinational decode of all fields
  always_comb begin
    d.fwd_div = 4'd8 - {1'b0, d.mode[PM_FWD_LSB +: 3]};
    d.fbk_div = (d.mode[PM_FBK_LSB +: 4] == 4'h0) ? 5'd16 : {1'b0, d.mode[PM_FBK_LSB +: 4]};
    d.core_div = plus_one(d.mode[PM_CORE_LSB +: 2]);
    d.peri_div = plus_one(d.mode[PM_PERI_LSB +: 2]);
    d.pci_div = plus_one(d.mode[PM_PCI_LSB +: 2]);
    d.ext_ratio = plus_one(d.mode[PM_EXT_LSB +: 2]) + 3'd1;
    case (d.straps[15:14])
      2'b00: d.strap_fwd = 4'd1;
      2'b01: d.strap_fwd = 4'd3;
      2'b10: d.strap_fwd = 4'd4;
      default: d.strap_fwd = 4'd6;
    endcase
    d.strap_fbk = plus_one(d.straps[13:12]);
    d.strap_tune = (d.straps[11:9] == 3'b111) ? 6'b100100 : 6'b010001 + {3'b000, d.straps[11:9]};
    d.strap_ext = plus_one(d.straps[2:1]) + 3'd1;
    d.boot_width = d.straps[0] ? 6'd32 : 6'd8;
  end
endmodule

// File: divisor_if.sv
// decoded clock divisor values passed between decoder and top
`timescale 1ns/1ps
interface divisor_if;
  logic [31:0] mode;
  logic [15:0] straps;
  logic [5:0] serial_div;
  logic [3:0] fwd_div;
  logic [4:0] fbk_div;
  logic [2:0] core_div;
  logic [2:0] peri_div;
  logic [2:0] pci_div;
  logic [2:0] ext_ratio;
  logic [3:0] strap_fwd;
  logic [2:0] strap_fbk;
  logic [5:0] strap_tune;
  logic [2:0] strap_ext;
  logic [5:0] boot_width;
  modport src (output mode, straps, serial_div, input fwd_div, fbk_div, core_div, peri_div,
    pci_div, ext_ratio, strap_fwd, strap_fbk, strap_tune, strap_ext, boot_width);
  modport dec (input mode, straps, serial_div, output fwd_div, fbk_div, core_div, peri_div,
    pci_div, ext_ratio, strap_fwd, strap_fbk, strap_tune, strap_ext, boot_width);
endinterface
